//--- bench/dfs_host.sv
// host master model: sends a valid message every gap cycles while on
// assumes mclk from the bench; on is a level from the bench
`timescale 1ns/1ps
`default_nettype none
module dfs_host #(
    parameter int GAP = 100
)
(
    input  wire logic mclk,
    input  wire logic on,
    output var logic  msg_valid
);
    int cnt = 0;
    initial msg_valid = 1'b0;
    always @(negedge mclk) begin
        cnt = (cnt >= GAP - 1) ? 0 : cnt + 1;
        msg_valid <= on && cnt == 0;
    end
endmodule
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the drive fault supervisor
// assumes dfs_top with a short tick and the host model on msg_valid
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dfs_pkg::*;
    logic        mclk, rst_n, class_400v, motor_running, err_reset;
    logic        reg_wr, reg_rd, on, msg_valid, reg_rvalid;
    logic        supply_phase_fault, output_phase_loss_fault;
    logic        link_fatal, link_warning, link_error_display, stop_request;
    logic [1:0]  stop_method;
    logic [9:0]  dc_ripple_volts;
    logic [6:0]  current_u_pct, current_v_pct, current_w_pct;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    int          num_errors, checks_done, cyc;

    dfs_top #(.TICK_CYCLES(10)) dfs_top_i (.mclk(mclk), .rst_n(rst_n), .class_400v(class_400v),
        .dc_ripple_volts(dc_ripple_volts), .current_u_pct(current_u_pct),
        .current_v_pct(current_v_pct), .current_w_pct(current_w_pct),
        .motor_running(motor_running), .msg_valid(msg_valid), .err_reset(err_reset),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .supply_phase_fault(supply_phase_fault),
        .output_phase_loss_fault(output_phase_loss_fault), .link_fatal(link_fatal),
        .link_warning(link_warning), .link_error_display(link_error_display),
        .stop_request(stop_request), .stop_method(stop_method));
    dfs_host #(.GAP(100)) dfs_host_i (.mclk(mclk), .on(on), .msg_valid(msg_valid));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task results;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            results();
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [15:0] a, input logic [15:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
        @(negedge mclk);
    endtask

    task rd(input logic [15:0] a, input logic [15:0] e);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd = 1'b0;
        chk(16'(reg_rvalid), 16'h0001);
        chk(reg_rdata, e);
        @(negedge mclk);
    endtask

    task pulse_reset;
        err_reset = 1'b1;
        @(negedge mclk);
        err_reset = 1'b0;
        @(negedge mclk);
    endtask

    task stop_host;
        for (int i = 0; i < 120 && msg_valid !== 1'b1; i++) @(negedge mclk);
        on = 1'b0;
    endtask

    initial begin
        {rst_n, class_400v, motor_running, err_reset, reg_wr, reg_rd} = 6'h00;
        {reg_addr, reg_wdata, dc_ripple_volts} = 42'h0;
        {current_u_pct, current_v_pct, current_w_pct} = {3{7'h32}};
        {num_errors, checks_done, cyc} = 96'h0;
        on = 1'b1;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        rd(ADDR_SUPPLY_LEVEL, 16'h0000);
        rd(ADDR_SUPPLY_TIME, 16'h0000);
        rd(ADDR_LINK_REACT, 16'h0000);
        wr(ADDR_SUPPLY_LEVEL, 16'h0065);
        rd(ADDR_SUPPLY_LEVEL, 16'h0000);
        wr(ADDR_SUPPLY_LEVEL, 16'h0064);
        rd(ADDR_SUPPLY_LEVEL, 16'h0064);
        wr(ADDR_SUPPLY_LEVEL, 16'h0007);
        wr(ADDR_SUPPLY_TIME, 16'h0100);
        rd(ADDR_SUPPLY_TIME, 16'h0000);
        dc_ripple_volts = 10'h01d;
        repeat (300) @(negedge mclk);
        chk(16'(supply_phase_fault), 16'h0000);
        wr(ADDR_SUPPLY_TIME, 16'h0001);
        dc_ripple_volts = 10'h01c;
        repeat (300) @(negedge mclk);
        chk(16'(supply_phase_fault), 16'h0000);
        class_400v = 1'b1;
        dc_ripple_volts = 10'h01d;
        repeat (300) @(negedge mclk);
        chk(16'(supply_phase_fault), 16'h0000);
        class_400v = 1'b0;
        repeat (95) @(negedge mclk);
        chk(16'(supply_phase_fault), 16'h0000);
        for (int i = 0; i < 250 && supply_phase_fault !== 1'b1; i++) @(negedge mclk);
        dc_ripple_volts = 10'h000;
        repeat (20) @(negedge mclk);
        chk(16'(supply_phase_fault), 16'h0001);
        pulse_reset();
        chk(16'(supply_phase_fault), 16'h0000);
        motor_running = 1'b1;
        wr(ADDR_OUTPUT_LEVEL, 16'h0005);
        current_v_pct = 7'h04;
        repeat (60) @(negedge mclk);
        chk(16'(output_phase_loss_fault), 16'h0000);
        current_v_pct = 7'h32;
        wr(ADDR_OUTPUT_TIME, 16'h0003);
        current_v_pct = 7'h04;
        repeat (20) @(negedge mclk);
        current_v_pct = 7'h32;
        repeat (5) @(negedge mclk);
        current_v_pct = 7'h04;
        repeat (20) @(negedge mclk);
        current_v_pct = 7'h32;
        repeat (5) @(negedge mclk);
        chk(16'(output_phase_loss_fault), 16'h0000);
        current_w_pct = 7'h04;
        for (int i = 0; i < 60 && output_phase_loss_fault !== 1'b1; i++) @(negedge mclk);
        chk(16'(output_phase_loss_fault), 16'h0001);
        current_w_pct = 7'h32;
        wr(ADDR_FAULT_HIST, 16'h0007);
        rd(ADDR_FAULT_HIST, {8'h00, FC_OUTPUT});
        rd(ADDR_FAULT_HIST, {8'h00, FC_SUPPLY});
        rd(ADDR_FAULT_HIST, 16'h0000);
        wr(ADDR_WP_INIT, 16'h0006);
        rd(ADDR_FAULT_HIST, 16'h0000);
        rd(ADDR_FAULT_HIST, 16'h0000);
        wr(ADDR_LINK_REACT, {13'h0, REACT_WARN});
        stop_host();
        repeat (190) @(negedge mclk);
        chk(16'(link_warning), 16'h0000);
        for (int i = 0; i < 40 && link_warning !== 1'b1; i++) @(negedge mclk);
        chk(16'({link_warning, link_fatal}), 16'h0002);
        chk(16'(link_error_display), 16'h0001);
        on = 1'b1;
        for (int i = 0; i < 150 && link_warning !== 1'b0; i++) @(negedge mclk);
        chk(16'(link_warning), 16'h0000);
        for (int r = 0; r < 3; r++) begin
            wr(ADDR_LINK_REACT, 16'(r));
            stop_host();
            for (int i = 0; i < 250 && link_fatal !== 1'b1; i++) @(negedge mclk);
            chk(16'({link_fatal, stop_request}), 16'h0003);
            chk(16'(stop_method), 16'(r));
            on = 1'b1;
            repeat (150) @(negedge mclk);
            chk(16'(link_fatal), 16'h0001);
            pulse_reset();
            chk(16'(link_fatal), 16'h0000);
        end
        wr(ADDR_LINK_REACT, {13'h0, REACT_NONE});
        on = 1'b0;
        repeat (300) @(negedge mclk);
        chk(16'({link_fatal, link_warning}), 16'h0000);
        wr(ADDR_LINK_REACT, 16'h0005);
        rd(ADDR_LINK_REACT, 16'h0004);
        results();
    end
endmodule
`default_nettype wire

//--- rtl/dfs_log_mem.sv
// four-entry fault log, newest at index 0
// assumes push and clear are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module dfs_log_mem
    import dfs_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       push,
    input  wire logic [7:0] push_data,
    input  wire logic       clear,
    input  wire logic [1:0] rd_idx,
    output logic      [7:0] rd_data
);
    logic [7:0] entry      [LOG_DEPTH];
    logic [7:0] next_entry [LOG_DEPTH];

    always_comb begin
        for (int i = 0; i < LOG_DEPTH; i++) begin
            next_entry[i] = entry[i];
        end
        if (clear) begin
            for (int i = 0; i < LOG_DEPTH; i++) begin
                next_entry[i] = 8'h00;
            end
        end else if (push) begin
            next_entry[0] = push_data;
            for (int i = 1; i < LOG_DEPTH; i++) begin
                next_entry[i] = entry[i-1];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < LOG_DEPTH; i++) begin
                entry[i] <= 8'h00;
            end
            rd_data <= 8'h00;
        end else begin
            for (int i = 0; i < LOG_DEPTH; i++) begin
                entry[i] <= next_entry[i];
            end
            rd_data <= entry[rd_idx];
        end
    end

endmodule
`default_nettype wire

//--- rtl/dfs_persist.sv
// persistence timer: condition must hold longer than limit ticks
// assumes tick is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`default_nettype none
module dfs_persist
    import dfs_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       cond,
    input  wire logic       enable,
    input  wire logic       tick,
    input  wire logic [7:0] limit,
    output logic            fire
);
    logic [8:0] count;
    logic [8:0] next_count;

    always_comb begin
        next_count = count;
        if (!enable || !cond) begin
            next_count = 9'h000;
        end else if (tick && count <= {1'b0, limit}) begin
            next_count = count + 9'h001;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 9'h000;
        end else begin
            count <= next_count;
        end
    end

    assign fire = count > {1'b0, limit};

    property p_restart;
        @(posedge mclk) disable iff (!rst_n)
        !cond |=> (count == 9'h000) && !fire;
    endproperty
    a_restart: assert property (p_restart)
        else $error("persistence count not restarted");

    property p_disabled;
        @(posedge mclk) disable iff (!rst_n)
        !enable |=> !fire;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("detection fired while disabled");

endmodule
`default_nettype wire

//--- rtl/dfs_pkg.sv
// drive fault supervisor: shared constants
// assumes a single 50 MHz control clock
package dfs_pkg;

    // timebase
    localparam int CLK_HZ        = 50_000_000;
    localparam int TENTH_MS      = 100;
    localparam int TENTH_CYCLES  = CLK_HZ / 1000 * TENTH_MS;
    localparam int TENTHS_PER_S  = 10;
    localparam int LINK_GAP_S    = 2;
    localparam int LINK_GAP_TENTHS = LINK_GAP_S * TENTHS_PER_S;

    // parameter numbers on the serial register port
    localparam logic [15:0] ADDR_WP_INIT      = 16'h0101;
    localparam logic [15:0] ADDR_LINK_REACT   = 16'h0197;
    localparam logic [15:0] ADDR_SUPPLY_LEVEL = 16'h01a6;
    localparam logic [15:0] ADDR_SUPPLY_TIME  = 16'h01a7;
    localparam logic [15:0] ADDR_OUTPUT_LEVEL = 16'h01a8;
    localparam logic [15:0] ADDR_OUTPUT_TIME  = 16'h01a9;
    localparam logic [15:0] ADDR_FAULT_HIST   = 16'h01b2;

    // setting limits and reset values
    localparam logic [15:0] LEVEL_MAX      = 16'h0064;
    localparam logic [15:0] TIME_MAX       = 16'h00ff;
    localparam logic [15:0] REACT_MAX      = 16'h0004;
    localparam logic [15:0] INIT_CLEAR_LOG = 16'h0006;
    localparam logic [6:0]  RST_LEVEL      = 7'h00;
    localparam logic [7:0]  RST_TIME       = 8'h00;
    localparam logic [2:0]  RST_REACT      = 3'h0;
    localparam logic [15:0] RST_WP         = 16'h0000;

    // bus voltage full scale per class, and percent full scale
    localparam logic [9:0]  FS_200V_CLASS = 10'h190;
    localparam logic [9:0]  FS_400V_CLASS = 10'h320;
    localparam logic [6:0]  PCT_FULL      = 7'h64;

    // timeout reactions
    localparam logic [2:0] REACT_COAST = 3'h0;
    localparam logic [2:0] REACT_DEC1  = 3'h1;
    localparam logic [2:0] REACT_DEC2  = 3'h2;
    localparam logic [2:0] REACT_WARN  = 3'h3;
    localparam logic [2:0] REACT_NONE  = 3'h4;

    // fault log codes
    localparam logic [7:0] FC_SUPPLY = 8'h01;
    localparam logic [7:0] FC_OUTPUT = 8'h02;
    localparam logic [7:0] FC_LINK   = 8'h03;
    localparam int         LOG_DEPTH = 4;

    typedef enum logic [1:0] {
        DFS_LK_OK,
        DFS_LK_WARN,
        DFS_LK_FATAL
    } dfs_link_t;

endpackage

//--- rtl/dfs_top.sv
// drive fault supervisor: phase faults, fault log, link timeout
// assumes measurements and register port on mclk; class strap async
`timescale 1ns/1ps
`default_nettype none
//Contract
// - flag supply-phase fault when bus ripple exceeds level longer than time.
// - supply-phase level accepts 0 to 100 percent, reset zero.
// - supply-phase time accepts 0 to 255 seconds, reset zero.
// - supply-phase detection off when level or time is zero.
// - flag output-phase loss when any phase current stays low too long while motor_running.
// - output-phase level 0 to 100 percent of rated current.
// - output-phase detection off when level or time is zero.
// - keep four newest faults, entry one newest, steps go older.
// - fault log is read only; writes change nothing.
// - writing 6 to init parameter erases the fault log.
// - with detection on, gap over 2 s between messages is timeout.
// - reactions 0,1,2 give fatal error and coast, decel 1, decel 2.
// - reaction 3 warns, keeps running, clears when messages resume.
// - reaction 4 disables detection; range 0 to 4, reset zero.
// - fatal timeout holds until error reset input.
module dfs_top
    import dfs_pkg::*;
#(
    parameter int TICK_CYCLES = TENTH_CYCLES
)
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        class_400v,
    input  wire logic [9:0]  dc_ripple_volts,
    input  wire logic [6:0]  current_u_pct,
    input  wire logic [6:0]  current_v_pct,
    input  wire logic [6:0]  current_w_pct,
    input  wire logic        motor_running,
    input  wire logic        msg_valid,
    input  wire logic        err_reset,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_rvalid,
    output logic             supply_phase_fault,
    output logic             output_phase_loss_fault,
    output logic             link_fatal,
    output logic             link_warning,
    output logic             link_error_display,
    output logic             stop_request,
    output logic      [1:0]  stop_method
);
    function automatic logic below_lvl(input logic [6:0] pct, input logic [6:0] lvl);
        below_lvl = pct < lvl;
    endfunction

    function automatic logic wr_hit(input logic [15:0] a, input logic [15:0] lim);
        wr_hit = reg_wr && (reg_addr == a) && (reg_wdata <= lim);
    endfunction

    // strap synchroniser
    logic       class_s1;
    logic       class_s2;

    // settings
    logic [6:0]  supply_level;
    logic [7:0]  supply_time;
    logic [6:0]  output_level;
    logic [7:0]  output_time;
    logic [2:0]  link_react;
    logic [15:0] wp_param;
    logic [6:0]  next_supply_level;
    logic [7:0]  next_supply_time;
    logic [6:0]  next_output_level;
    logic [7:0]  next_output_time;
    logic [2:0]  next_link_react;
    logic [15:0] next_wp_param;
    logic        log_clear;

    // timebase
    logic [22:0] pre_cnt;
    logic [3:0]  sec_cnt;
    logic [22:0] next_pre_cnt;
    logic [3:0]  next_sec_cnt;
    logic        tenth_tick;
    logic        sec_tick;

    // detection
    logic [16:0] ripple_scaled;
    logic [16:0] level_scaled;
    logic        supply_cond;
    logic        output_cond;
    logic        supply_en;
    logic        output_en;
    logic        sup_fire;
    logic        out_fire;

    // faults and log
    logic        next_pf;
    logic        next_lf;
    logic        pf_new;
    logic        lf_new;
    logic        lk_new;
    logic        log_push;
    logic [7:0]  log_code;
    logic [2:0]  log_count;
    logic [1:0]  hist_ptr;
    logic [2:0]  next_log_count;
    logic [1:0]  next_hist_ptr;
    logic [7:0]  hist_data;

    // link supervision
    dfs_link_t   lk_state;
    dfs_link_t   next_lk_state;
    logic [4:0]  gap_cnt;
    logic [4:0]  next_gap_cnt;
    logic [1:0]  next_stop_method;
    logic        timeout;

    // read port
    logic [15:0] next_rdata;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            class_s1 <= 1'b0;
            class_s2 <= 1'b0;
        end else begin
            class_s1 <= class_400v;
            class_s2 <= class_s1;
        end
    end

    // setting registers; out of range writes are dropped
    always_comb begin
        next_supply_level = supply_level;
        next_supply_time  = supply_time;
        next_output_level = output_level;
        next_output_time  = output_time;
        next_link_react   = link_react;
        next_wp_param     = wp_param;
        if (wr_hit(ADDR_SUPPLY_LEVEL, LEVEL_MAX)) begin
            next_supply_level = reg_wdata[6:0];
        end
        if (wr_hit(ADDR_SUPPLY_TIME, TIME_MAX)) begin
            next_supply_time = reg_wdata[7:0];
        end
        if (wr_hit(ADDR_OUTPUT_LEVEL, LEVEL_MAX)) begin
            next_output_level = reg_wdata[6:0];
        end
        if (wr_hit(ADDR_OUTPUT_TIME, TIME_MAX)) begin
            next_output_time = reg_wdata[7:0];
        end
        if (wr_hit(ADDR_LINK_REACT, REACT_MAX)) begin
            next_link_react = reg_wdata[2:0];
        end
        if (reg_wr && reg_addr == ADDR_WP_INIT) begin
            next_wp_param = reg_wdata;
        end
    end

    assign log_clear = reg_wr && reg_addr == ADDR_WP_INIT && reg_wdata == INIT_CLEAR_LOG;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            supply_level <= RST_LEVEL;
            supply_time  <= RST_TIME;
            output_level <= RST_LEVEL;
            output_time  <= RST_TIME;
            link_react   <= RST_REACT;
            wp_param     <= RST_WP;
        end else begin
            supply_level <= next_supply_level;
            supply_time  <= next_supply_time;
            output_level <= next_output_level;
            output_time  <= next_output_time;
            link_react   <= next_link_react;
            wp_param     <= next_wp_param;
        end
    end

    // tenth-second and second ticks
    always_comb begin
        tenth_tick   = pre_cnt == 23'(TICK_CYCLES - 1);
        sec_tick     = tenth_tick && sec_cnt == 4'(TENTHS_PER_S - 1);
        next_pre_cnt = tenth_tick ? 23'h00_0000 : pre_cnt + 23'h00_0001;
        next_sec_cnt = sec_cnt;
        if (tenth_tick) begin
            next_sec_cnt = sec_tick ? 4'h0 : sec_cnt + 4'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= 23'h00_0000;
            sec_cnt <= 4'h0;
        end else begin
            pre_cnt <= next_pre_cnt;
            sec_cnt <= next_sec_cnt;
        end
    end

    // ripple volts * 100 against level * full scale
    assign ripple_scaled = 17'(dc_ripple_volts) * 17'(PCT_FULL);
    assign level_scaled  = 17'(supply_level) * (class_s2 ? 17'(FS_400V_CLASS) : 17'(FS_200V_CLASS));
    assign supply_cond   = ripple_scaled > level_scaled;
    assign supply_en     = supply_level != RST_LEVEL && supply_time != RST_TIME;
    assign output_en     = output_level != RST_LEVEL && output_time != RST_TIME;
    assign output_cond   = motor_running && (below_lvl(current_u_pct, output_level)
                        || below_lvl(current_v_pct, output_level)
                        || below_lvl(current_w_pct, output_level));

    dfs_persist u_supply (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .cond   (supply_cond),
        .enable (supply_en),
        .tick   (sec_tick),
        .limit  (supply_time),
        .fire   (sup_fire)
    );

    dfs_persist u_output (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .cond   (output_cond),
        .enable (output_en),
        .tick   (tenth_tick),
        .limit  (output_time),
        .fire   (out_fire)
    );

    // fault flags: one log push per cycle, new detection wins over reset
    always_comb begin
        pf_new   = sup_fire && !supply_phase_fault;
        lf_new   = out_fire && !output_phase_loss_fault && !pf_new;
        next_pf  = pf_new || (supply_phase_fault && (!err_reset || sup_fire));
        next_lf  = lf_new || (output_phase_loss_fault && (!err_reset || out_fire));
        log_push = pf_new || lf_new || lk_new;
        log_code = pf_new ? FC_SUPPLY : (lf_new ? FC_OUTPUT : FC_LINK);
        next_log_count = log_count;
        next_hist_ptr  = hist_ptr;
        if (log_clear) begin
            next_log_count = 3'h0;
            next_hist_ptr  = 2'h0;
        end else if (log_push) begin
            next_log_count = (log_count == 3'(LOG_DEPTH)) ? log_count : log_count + 3'h1;
            next_hist_ptr  = 2'h0;
        end else if (reg_rd && reg_addr == ADDR_FAULT_HIST) begin
            next_hist_ptr = hist_ptr + 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            supply_phase_fault      <= 1'b0;
            output_phase_loss_fault <= 1'b0;
            log_count               <= 3'h0;
            hist_ptr                <= 2'h0;
        end else begin
            supply_phase_fault      <= next_pf;
            output_phase_loss_fault <= next_lf;
            log_count               <= next_log_count;
            hist_ptr                <= next_hist_ptr;
        end
    end

    dfs_log_mem u_log (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .push      (log_push),
        .push_data (log_code),
        .clear     (log_clear),
        .rd_idx    (hist_ptr),
        .rd_data   (hist_data)
    );

    // link timeout supervision
    assign timeout = gap_cnt > 5'(LINK_GAP_TENTHS);
    assign lk_new  = next_lk_state == DFS_LK_FATAL && lk_state != DFS_LK_FATAL;

    always_comb begin
        next_gap_cnt     = gap_cnt;
        next_lk_state    = lk_state;
        next_stop_method = stop_method;
        if (msg_valid || link_react == REACT_NONE) begin
            next_gap_cnt = 5'h00;
        end else if (tenth_tick && !timeout) begin
            next_gap_cnt = gap_cnt + 5'h01;
        end
        unique case (lk_state)
            DFS_LK_OK: begin
                if (timeout && link_react != REACT_NONE && !pf_new && !lf_new) begin
                    if (link_react == REACT_WARN) begin
                        next_lk_state = DFS_LK_WARN;
                    end else begin
                        next_lk_state    = DFS_LK_FATAL;
                        next_stop_method = link_react[1:0];
                    end
                end
            end
            DFS_LK_WARN: begin
                if (msg_valid || link_react == REACT_NONE) begin
                    next_lk_state = DFS_LK_OK;
                end
            end
            DFS_LK_FATAL: begin
                if (err_reset) begin
                    next_lk_state = DFS_LK_OK;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gap_cnt     <= 5'h00;
            lk_state    <= DFS_LK_OK;
            stop_method <= REACT_COAST[1:0];
        end else begin
            gap_cnt     <= next_gap_cnt;
            lk_state    <= next_lk_state;
            stop_method <= next_stop_method;
        end
    end

    assign link_fatal         = lk_state == DFS_LK_FATAL;
    assign link_warning       = lk_state == DFS_LK_WARN;
    assign link_error_display = link_fatal || link_warning;
    assign stop_request       = link_fatal;

    // register read: one cycle latency, unmapped reads zero
    always_comb begin
        next_rdata = 16'h0000;
        unique case (reg_addr)
            ADDR_SUPPLY_LEVEL: next_rdata = {9'h000, supply_level};
            ADDR_SUPPLY_TIME:  next_rdata = {8'h00, supply_time};
            ADDR_OUTPUT_LEVEL: next_rdata = {9'h000, output_level};
            ADDR_OUTPUT_TIME:  next_rdata = {8'h00, output_time};
            ADDR_LINK_REACT:   next_rdata = {13'h0000, link_react};
            ADDR_WP_INIT:      next_rdata = wp_param;
            ADDR_FAULT_HIST:   next_rdata = {8'h00, hist_data};
            default:           next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= reg_rd ? next_rdata : reg_rdata;
            reg_rvalid <= reg_rd;
        end
    end

    property p_level_range;
        @(posedge mclk) disable iff (!rst_n)
        supply_level <= LEVEL_MAX[6:0] && output_level <= LEVEL_MAX[6:0];
    endproperty
    a_level_range: assert property (p_level_range)
        else $error("level setting out of range");

    property p_pf_set;
        @(posedge mclk) disable iff (!rst_n)
        sup_fire |=> supply_phase_fault;
    endproperty
    a_pf_set: assert property (p_pf_set)
        else $error("supply-phase fault not raised");

    property p_log_clear;
        @(posedge mclk) disable iff (!rst_n)
        log_clear |=> log_count == 3'h0 && hist_ptr == 2'h0;
    endproperty
    a_log_clear: assert property (p_log_clear)
        else $error("fault log not erased");

    property p_fatal_hold;
        @(posedge mclk) disable iff (!rst_n)
        (link_fatal && !err_reset) |=> link_fatal && $stable(stop_method);
    endproperty
    a_fatal_hold: assert property (p_fatal_hold)
        else $error("fatal timeout released early");

    property p_warn_clear;
        @(posedge mclk) disable iff (!rst_n)
        (link_warning && msg_valid) |=> !link_warning && !link_fatal;
    endproperty
    a_warn_clear: assert property (p_warn_clear)
        else $error("warning not cleared on message");

    property p_no_detect;
        @(posedge mclk) disable iff (!rst_n)
        (link_react == REACT_NONE && !link_fatal) |=> !link_fatal && gap_cnt == 5'h00;
    endproperty
    a_no_detect: assert property (p_no_detect)
        else $error("timeout detected with detection off");

    property p_fatal_entry;
        @(posedge mclk) disable iff (!rst_n)
        $rose(link_fatal) |-> $past(timeout) && stop_method == $past(link_react[1:0]);
    endproperty
    a_fatal_entry: assert property (p_fatal_entry)
        else $error("fatal timeout without gap or wrong stop method");

endmodule
`default_nettype wire
